// ===== rtl/sram_pkg.sv
// What this block does
// - two banks, 288 and 256 Kbits
// - nine and eight columns of 2Kx16
// - each bank has core and io ports
// - two core (on separate banks) plus one io access per cycle
// - capacity shared by 16/32/48-bit words
// - every location takes 16, 32, 48-bit words, except that lanes past the bank end are dropped
// - core runs single cycle with off-chip operand
// - memory runs at core instruction rate
package sram_pkg;
  localparam int col_width = 16;           // bits per column
  localparam int col_depth = 2048;         // locations per column
  localparam int col_addr_w = 11;          // column address width
  localparam int bank0_cols = 9;           // first bank columns
  localparam int bank1_cols = 8;           // second bank columns
  localparam int addr_w = 16;              // 16-bit word address, 34K space
  localparam int data_w = 48;              // widest word
  localparam int core_mhz = 125;           // core instruction rate
  // access width codes
  typedef enum logic [1:0] {
    width_16 = 2'h0,
    width_32 = 2'h1,
    width_48 = 2'h2
  } width_t;
  // number of 16-bit columns a width uses
  function automatic logic [1:0] width_cols(width_t w);
    unique case (w)
      width_16: width_cols = 2'h1;
      width_32: width_cols = 2'h2;
      default: width_cols = 2'h3;
    endcase
  endfunction : width_cols
endpackage : sram_pkg

// ===== rtl/sram_port_if.sv
// one access port between the top and a bank
interface sram_port_if;
  logic req;                     // access this cycle
  logic we;                      // write when high
  logic [sram_pkg::addr_w-1:0] addr;  // 16-bit word address within bank
  sram_pkg::width_t width;            // access width
  logic [sram_pkg::data_w-1:0] wdata; // write data, low bits used
  logic [sram_pkg::data_w-1:0] rdata; // read data, registered
  modport master (output req, we, addr, width, wdata, input rdata);
  modport slave (input req, we, addr, width, wdata, output rdata);
endinterface : sram_port_if

// ===== rtl/sram_bank.sv
// one dual-ported bank built from 16-bit columns
module sram_bank #(
  parameter int cols = sram_pkg::bank0_cols
) (
  input wire logic clock,
  sram_port_if.slave core_p,
  sram_port_if.slave io_p
);
  localparam int words = cols * sram_pkg::col_depth;
  // 16-bit storage; a 2K x cols array of columns flattened
  logic [15:0] mem [words];
  logic [47:0] core_rd_q;
  logic [47:0] io_rd_q;
  // write one 16-bit word per lane; core writes each lane after the io's same lane, so it wins when both start at one address
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (io_p.req && io_p.we && i < sram_pkg::width_cols(io_p.width)
          && int'(io_p.addr) + i < words) begin
        mem[int'(io_p.addr) + i] <= io_p.wdata[16*i +: 16];
      end
      if (core_p.req && core_p.we && i < sram_pkg::width_cols(core_p.width)
          && int'(core_p.addr) + i < words) begin
        mem[int'(core_p.addr) + i] <= core_p.wdata[16*i +: 16];
      end
    end
  end
  // both ports read in the same cycle, old contents returned
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (core_p.req && !core_p.we) begin
        core_rd_q[16*i +: 16] <= (i < sram_pkg::width_cols(core_p.width)
          && int'(core_p.addr) + i < words) ?
          mem[int'(core_p.addr) + i] : 16'h0000;
      end
      if (io_p.req && !io_p.we) begin
        io_rd_q[16*i +: 16] <= (i < sram_pkg::width_cols(io_p.width)
          && int'(io_p.addr) + i < words) ?
          mem[int'(io_p.addr) + i] : 16'h0000;
      end
    end
  end
  assign core_p.rdata = core_rd_q;
  assign io_p.rdata = io_rd_q;
endmodule : sram_bank

// ===== rtl/dual_port_onchip_sram.sv
// two banks; core data and program buses and the io processor port
module dual_port_onchip_sram (
  input wire logic clock,
  input wire logic reset,
  // data_memory_bus
  input wire logic dm_req,
  input wire logic dm_we,
  input wire logic dm_bank,
  input wire logic [15:0] dm_addr,
  input wire sram_pkg::width_t dm_width,
  input wire logic [47:0] dm_wdata,
  output logic [47:0] dm_rdata,
  // program_memory_bus
  input wire logic pm_req,
  input wire logic pm_we,
  input wire logic pm_bank,
  input wire logic [15:0] pm_addr,
  input wire sram_pkg::width_t pm_width,
  input wire logic [47:0] pm_wdata,
  output logic [47:0] pm_rdata,
  // io_processor port
  input wire logic io_req,
  input wire logic io_we,
  input wire logic io_bank,
  input wire logic [15:0] io_addr,
  input wire sram_pkg::width_t io_width,
  input wire logic [47:0] io_wdata,
  output logic [47:0] io_rdata,
  // both core buses aimed at one bank: program bus was not served
  output logic core_conflict
);
  sram_port_if core0 ();
  sram_port_if core1 ();
  sram_port_if io0 ();
  sram_port_if io1 ();
  logic clash; // both core buses want one bank
  logic dm_sel_q, dm_sel_d; // bank that served data bus last cycle
  logic pm_sel_q, pm_sel_d;
  logic io_sel_q, io_sel_d;
  logic clash_q, clash_d;
  // core bus steering; data bus wins a clash, program bus is dropped and flagged
  always_comb begin
    clash = dm_req && pm_req && (dm_bank == pm_bank);
    // bank 0 core port
    core0.req = (dm_req && !dm_bank) || (pm_req && !pm_bank && !clash);
    core0.we = (dm_req && !dm_bank) ? dm_we : pm_we;
    core0.addr = (dm_req && !dm_bank) ? dm_addr : pm_addr;
    core0.width = (dm_req && !dm_bank) ? dm_width : pm_width;
    core0.wdata = (dm_req && !dm_bank) ? dm_wdata : pm_wdata;
    // bank 1 core port
    core1.req = (dm_req && dm_bank) || (pm_req && pm_bank && !clash);
    core1.we = (dm_req && dm_bank) ? dm_we : pm_we;
    core1.addr = (dm_req && dm_bank) ? dm_addr : pm_addr;
    core1.width = (dm_req && dm_bank) ? dm_width : pm_width;
    core1.wdata = (dm_req && dm_bank) ? dm_wdata : pm_wdata;
    // io port goes straight to its bank
    io0.req = io_req && !io_bank;
    io1.req = io_req && io_bank;
    io0.we = io_we;
    io1.we = io_we;
    io0.addr = io_addr;
    io1.addr = io_addr;
    io0.width = io_width;
    io1.width = io_width;
    io0.wdata = io_wdata;
    io1.wdata = io_wdata;
    dm_sel_d = dm_bank;
    pm_sel_d = pm_bank;
    io_sel_d = io_bank;
    clash_d = clash;
  end
  // remember which bank answers next cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dm_sel_q <= 1'b0;
      pm_sel_q <= 1'b0;
      io_sel_q <= 1'b0;
      clash_q <= 1'b0;
    end else begin
      dm_sel_q <= dm_sel_d;
      pm_sel_q <= pm_sel_d;
      io_sel_q <= io_sel_d;
      clash_q <= clash_d;
    end
  end
  // first bank: nine columns
  sram_bank #(.cols(sram_pkg::bank0_cols)) bank0 (
    .clock(clock),
    .core_p(core0),
    .io_p(io0)
  );
  // second bank: eight columns
  sram_bank #(.cols(sram_pkg::bank1_cols)) bank1 (
    .clock(clock),
    .core_p(core1),
    .io_p(io1)
  );
  // one-cycle reads at the core rate
  assign dm_rdata = dm_sel_q ? core1.rdata : core0.rdata;
  assign pm_rdata = pm_sel_q ? core1.rdata : core0.rdata;
  assign io_rdata = io_sel_q ? io1.rdata : io0.rdata;
  assign core_conflict = clash_q;
  // both core buses aimed at one bank this cycle
  sequence s_core_clash;
    dm_req && pm_req && (dm_bank == pm_bank);
  endsequence
  // data bus writes one 16-bit cell, nothing else moving
  sequence s_dm_write16;
    dm_req && dm_we && !pm_req && !io_req &&
    dm_width == sram_pkg::width_16;
  endsequence
  // data bus reads back the cell written the cycle before
  sequence s_dm_read_same;
    dm_req && !dm_we && dm_width == sram_pkg::width_16 &&
    dm_bank == $past(dm_bank) && dm_addr == $past(dm_addr);
  endsequence
  // data bus and io write one 16-bit cell together
  sequence s_both_write;
    dm_req && dm_we && io_req && io_we && dm_bank == io_bank &&
    dm_addr == io_addr && dm_width == sram_pkg::width_16 &&
    io_width == sram_pkg::width_16 && !pm_req;
  endsequence
  // io reads the cell that both wrote, with no core bus writing
  sequence s_io_read_same;
    io_req && !io_we && io_bank == $past(io_bank) &&
    io_addr == $past(io_addr) && io_width == sram_pkg::width_16 &&
    !(dm_req && dm_we) && !(pm_req && pm_we);
  endsequence
  // a clash is reported the following cycle
  a_clash_flag: assert property (@(posedge clock) disable iff (reset)
    s_core_clash |=> core_conflict)
    else $error("core clash not flagged");
  // separate banks never clash
  a_no_clash: assert property (@(posedge clock) disable iff (reset)
    (dm_req && pm_req && dm_bank != pm_bank) |=> !core_conflict)
    else $error("false core clash");
  // data bus always reaches its bank
  a_dm_served: assert property (@(posedge clock) disable iff (reset)
    dm_req |-> (dm_bank ? core1.req : core0.req))
    else $error("data bus not served");
  // io always reaches its bank, independent of core
  a_io_served: assert property (@(posedge clock) disable iff (reset)
    io_req |-> (io_bank ? io1.req : io0.req))
    else $error("io not served");
  // write then read same place, same width, returns data
  a_dm_readback: assert property (@(posedge clock) disable iff (reset)
    s_dm_write16 ##1 s_dm_read_same
    |=> dm_rdata[15:0] == $past(dm_wdata[15:0], 2))
    else $error("readback mismatch");
  // core wins when both write the same place
  a_core_wins: assert property (@(posedge clock) disable iff (reset)
    s_both_write ##1 s_io_read_same
    |=> io_rdata[15:0] == $past(dm_wdata[15:0], 2))
    else $error("io won write clash");
  // program bus dropped on a clash at bank 0
  a_pm_dropped: assert property (@(posedge clock) disable iff (reset)
    (dm_req && pm_req && dm_bank == pm_bank && !dm_bank) |->
    core0.addr == dm_addr)
    else $error("program bus took bank on clash");
  // program bus reaches its bank when the data bus is elsewhere
  a_pm_served: assert property (@(posedge clock) disable iff (reset)
    (pm_req && !(dm_req && dm_bank == pm_bank)) |->
    (pm_bank ? core1.req : core0.req))
    else $error("program bus not served");
  // program bus address steered to its bank unchanged
  a_pm_steer: assert property (@(posedge clock) disable iff (reset)
    (pm_req && !(dm_req && dm_bank == pm_bank)) |->
    (pm_bank ? core1.addr : core0.addr) == pm_addr)
    else $error("program bus address lost");
  // data bus address and direction steered to its bank
  a_dm_steer: assert property (@(posedge clock) disable iff (reset)
    dm_req |-> ((dm_bank ? core1.addr : core0.addr) == dm_addr &&
    (dm_bank ? core1.we : core0.we) == dm_we))
    else $error("data bus steering lost");
  // io never touches both banks
  a_io_one_bank: assert property (@(posedge clock) disable iff (reset)
    io_req |-> !(io0.req && io1.req))
    else $error("io reached both banks");
  // idle core buses leave both core ports quiet
  a_core_idle: assert property (@(posedge clock) disable iff (reset)
    (!dm_req && !pm_req) |-> (!core0.req && !core1.req))
    else $error("core port busy while idle");
  // both core buses and io together in one cycle
  a_three_way: assert property (@(posedge clock) disable iff (reset)
    (dm_req && pm_req && io_req && dm_bank != pm_bank) |->
    (core0.req && core1.req && (io0.req || io1.req)))
    else $error("three accesses not served");
endmodule : dual_port_onchip_sram

// ===== tb/io_dma_model.sv
// io processor side: one access per cycle, bus scrambled when released
module io_dma_model (
  output logic io_req,
  output logic io_we,
  output logic io_bank,
  output logic [15:0] io_addr,
  output sram_pkg::width_t io_width,
  output logic [47:0] io_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle at time zero
  initial begin
    {io_req, io_we, io_bank, io_addr, io_wdata} = '0;
    io_width = sram_pkg::width_16;
  end
  // one request held until the next rising edge
  task issue(input logic w, b, input logic [15:0] a,
             input sram_pkg::width_t wd, input logic [47:0] v);
    io_req <= 1'b1;
    io_we <= w;
    io_bank <= b;
    io_addr <= a;
    io_width <= wd;
    io_wdata <= v;
  endtask : issue
  // released bus shows a changing pattern, not the last value
  task idle();
    io_req <= 1'b0;
    io_addr <= ~io_addr;
    io_wdata <= ~io_wdata;
  endtask : idle
endmodule : io_dma_model

// ===== tb/test_dual_port_onchip_sram.sv
module test_dual_port_onchip_sram;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0; // 125 MHz core clock
  logic reset = 1'b1; // async, active high
  logic dm_req = 1'b0, dm_we = 1'b0, dm_bank = 1'b0;
  logic pm_req = 1'b0, pm_we = 1'b0, pm_bank = 1'b0;
  logic [15:0] dm_addr = 16'h0, pm_addr = 16'h0;
  sram_pkg::width_t dm_width = sram_pkg::width_16;
  sram_pkg::width_t pm_width = sram_pkg::width_16;
  logic [47:0] dm_wdata = 48'h0, pm_wdata = 48'h0;
  logic io_req, io_we, io_bank, core_conflict;
  logic [15:0] io_addr;
  sram_pkg::width_t io_width;
  logic [47:0] io_wdata, dm_rdata, pm_rdata, io_rdata;
  int miscompares = 0, checked = 0;
  always #4 clock = ~clock;
  dual_port_onchip_sram dut_u (.clock(clock), .reset(reset),
    .dm_req(dm_req), .dm_we(dm_we), .dm_bank(dm_bank), .dm_addr(dm_addr),
    .dm_width(dm_width), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
    .pm_req(pm_req), .pm_we(pm_we), .pm_bank(pm_bank), .pm_addr(pm_addr),
    .pm_width(pm_width), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata),
    .io_req(io_req), .io_we(io_we), .io_bank(io_bank), .io_addr(io_addr),
    .io_width(io_width), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .core_conflict(core_conflict));
  io_dma_model io_u (.io_req(io_req), .io_we(io_we), .io_bank(io_bank),
    .io_addr(io_addr), .io_width(io_width), .io_wdata(io_wdata));
  // compare seen against expected
  task check(input logic [47:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // core request on data bus (p=0) or program bus (p=1)
  task core(input logic p, w, b, input logic [15:0] a,
            input sram_pkg::width_t wd, input logic [47:0] v);
    if (p) begin
      {pm_req, pm_we, pm_bank, pm_addr, pm_wdata} <= {1'b1, w, b, a, v};
      pm_width <= wd;
    end else begin
      {dm_req, dm_we, dm_bank, dm_addr, dm_wdata} <= {1'b1, w, b, a, v};
      dm_width <= wd;
    end
  endtask : core
  // taking edge, then release all buses and let outputs settle
  task step();
    @(posedge clock);
    {dm_req, pm_req} <= 2'h0;
    dm_wdata <= ~dm_wdata;
    pm_wdata <= ~pm_wdata;
    io_u.idle();
    #2;
  endtask : step
  // each width written and read back, then a lane of a 48-bit word
  task s_widths();
    for (int i = 0; i < 3; i++) begin
      @(posedge clock) core(0, 1, 0, 16'h0100, sram_pkg::width_t'(i),
                            48'h1234_5678_9abc);
      step();
      @(posedge clock) core(0, 0, 0, 16'h0100, sram_pkg::width_t'(i), 0);
      step();
      check(dm_rdata, 48'h1234_5678_9abc & (i == 0 ? 48'hffff :
            i == 1 ? 48'hffff_ffff : '1));
    end
    @(posedge clock) core(0, 0, 0, 16'h0102, sram_pkg::width_16, 0);
    step();
    check(dm_rdata, 48'h1234);
  endtask : s_widths
  // two core transfers on separate banks plus one io transfer
  task s_three();
    @(posedge clock) core(0, 1, 0, 16'h000a, sram_pkg::width_48, 48'h1);
    core(1, 1, 1, 16'h000a, sram_pkg::width_48, 48'h2);
    io_u.issue(1, 1, 16'h0014, sram_pkg::width_48, 48'h3);
    step();
    check(core_conflict, 1'b0);
    @(posedge clock) core(0, 0, 0, 16'h000a, sram_pkg::width_48, 0);
    core(1, 0, 1, 16'h000a, sram_pkg::width_48, 0);
    io_u.issue(0, 1, 16'h0014, sram_pkg::width_48, 0);
    step();
    check({dm_rdata, pm_rdata, io_rdata}, {48'h1, 48'h2, 48'h3});
  endtask : s_three
  // both core buses on one bank: program bus dropped and flagged
  task s_clash();
    @(posedge clock) core(0, 1, 0, 16'h001f, sram_pkg::width_16, 48'h6);
    step();
    @(posedge clock) core(0, 1, 0, 16'h001e, sram_pkg::width_16, 48'h4);
    core(1, 1, 0, 16'h001f, sram_pkg::width_16, 48'h5);
    step();
    check(core_conflict, 1'b1);
    @(posedge clock) core(0, 0, 0, 16'h001f, sram_pkg::width_16, 0);
    step();
    check(dm_rdata, 48'h6);
  endtask : s_clash
  // same-cell clashes between core and io ports
  task s_same();
    @(posedge clock) core(0, 1, 1, 16'h0028, sram_pkg::width_32, 48'h7);
    io_u.issue(1, 1, 16'h0028, sram_pkg::width_32, 48'h8);
    step();
    @(posedge clock) core(0, 0, 1, 16'h0028, sram_pkg::width_32, 0);
    io_u.issue(1, 1, 16'h0028, sram_pkg::width_32, 48'h9);
    step();
    check(dm_rdata, 48'h7);
    @(posedge clock) io_u.issue(0, 1, 16'h0028, sram_pkg::width_32, 0);
    step();
    check(io_rdata, 48'h9);
  endtask : s_same
  // back to back write and read, then core and io write one cell
  task s_b2b();
    @(posedge clock) core(0, 1, 0, 16'h0030, sram_pkg::width_16, 48'hbeef);
    @(posedge clock) core(0, 0, 0, 16'h0030, sram_pkg::width_16, 0);
    step();
    check(dm_rdata, 48'hbeef);
    @(posedge clock) core(0, 1, 0, 16'h0031, sram_pkg::width_16, 48'h11);
    io_u.issue(1, 0, 16'h0031, sram_pkg::width_16, 48'h22);
    @(posedge clock) io_u.issue(0, 0, 16'h0031, sram_pkg::width_16, 0);
    dm_req <= 1'b0;
    step();
    check(io_rdata, 48'h11);
  endtask : s_b2b
  // last cell of each bank, then one past the second bank
  task s_edge();
    @(posedge clock) core(0, 1, 0, 16'h47ff, sram_pkg::width_16, 48'ha5);
    core(1, 1, 1, 16'h3fff, sram_pkg::width_16, 48'h5a);
    step();
    @(posedge clock) core(0, 0, 0, 16'h47ff, sram_pkg::width_16, 0);
    core(1, 0, 1, 16'h3fff, sram_pkg::width_16, 0);
    io_u.issue(0, 1, 16'h4000, sram_pkg::width_16, 0);
    step();
    check({dm_rdata, pm_rdata, io_rdata}, {48'ha5, 48'h5a, 48'h0});
  endtask : s_edge
  // verdict and end of run
  task complete_run();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // reset for two cycles, then every scenario
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    s_widths();
    s_three();
    s_clash();
    s_same();
    s_b2b();
    s_edge();
    complete_run();
  end
endmodule : test_dual_port_onchip_sram
